/* File: hw/cycle_tally_counter.sv */
`timescale 1ns/100ps

// Free-running tally advanced once per cycle of the slower tally clock rate.
module cycle_tally_counter #(
    parameter int COUNT_WIDTH = 32,
    parameter int DIV = gp_timer_pkg::TALLY_DIV,
    parameter int SETTLE_CYCLES = gp_timer_pkg::TALLY_SETTLE_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    output logic [COUNT_WIDTH-1:0] count_out,
    output logic wrap_out
);

    // ==========================================================
    // Elaboration checks.
    // ==========================================================
    generate
        if (COUNT_WIDTH < 2 || DIV < 1 || DIV > 255 || SETTLE_CYCLES < 1 || SETTLE_CYCLES > 255)
        begin : g_bad_param
            $error("cycle_tally_counter: unsupported parameter value.");
        end
    endgenerate

    logic [7:0] phase_q;
    logic [7:0] phase_d;
    logic [7:0] settle_q;
    logic [7:0] settle_d;
    logic [COUNT_WIDTH-1:0] count_q;
    logic [COUNT_WIDTH-1:0] count_d;
    logic wrap_q;
    logic wrap_d;
    logic tick;

    // ==========================================================
    // Next-state logic.
    // ==========================================================
    // The settle window holds the tally at zero after reset, so early reads see a cleared value.
    always_comb
    begin
        phase_d = phase_q;
        settle_d = settle_q;
        count_d = count_q;
        wrap_d = 1'b0;
        tick = 1'b0;
        if (settle_q != 8'h00)
        begin
            settle_d = settle_q - 8'h01;
        end
        else if (phase_q == 8'(DIV - 1))
        begin
            phase_d = 8'h00;
            tick = 1'b1;
        end
        else
        begin
            phase_d = phase_q + 8'h01;
        end
        if (tick)
        begin
            count_d = count_q + {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
            wrap_d = &count_q;
        end
    end

    // Nothing here looks at power state, but the tally holds its value while ce_in is low.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            phase_q <= 8'h00;
            settle_q <= 8'(SETTLE_CYCLES);
            count_q <= '0;
            wrap_q <= 1'b0;
        end
        else if (ce_in)
        begin
            phase_q <= phase_d;
            settle_q <= settle_d;
            count_q <= count_d;
            wrap_q <= wrap_d;
        end
    end

    assign count_out = count_q;
    assign wrap_out = wrap_q;

endmodule : cycle_tally_counter

/* File: hw/gp_timer_and_cycle_counter.sv */
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps

// Behaviour
// - Writing one to config bit 29 runs the timer; writing zero halts it; resets zero.
// - On run bit falling from one to zero, preload field is forced to FFFFh.
// - Config bits 15-0 hold a writable preload, reset FFFFh, loaded into the timer.
// - Count register shows the live 16-bit timer value, FFFFh after reset, upper bits zero.
// - A running timer raises host interrupts at intervals set by the preload.
// - Read-only 32-bit tally starts at zero at reset, advances each 25MHz cycle.
// - At its maximum value the tally wraps to zero and keeps counting.
// - In half-word mode the first tally read latches all 32 bits for the second.
// - After reset the tally may take up to 160ns to clear; early reads may be stale.
// - The tally keeps counting in every power state; here it holds while ce_in is low.
module gp_timer_and_cycle_counter #(
    parameter int TICK_DIV = gp_timer_pkg::TIMER_TICK_DIV_DEFAULT,
    parameter int TALLY_WIDTH = 32
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire gp_timer_pkg::reg_req_type reg_req_in,
    output logic [31:0] rd_data_out,
    output logic irq_out
);

    // ==========================================================
    // Elaboration checks.
    // ==========================================================
    generate
        if (TICK_DIV < 1 || TICK_DIV > 65535 || TALLY_WIDTH < 2 || TALLY_WIDTH > 32)
        begin : g_bad_param
            $error("gp_timer_and_cycle_counter: unsupported parameter value.");
        end
    endgenerate

    // ==========================================================
    // Declarations.
    // ==========================================================
    gp_timer_pkg::timer_state_type state_q;
    gp_timer_pkg::timer_state_type state_d;
    logic [15:0] preload_q;
    logic [15:0] preload_d;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [15:0] prescale_q;
    logic [15:0] prescale_d;
    logic timer_event;
    logic [gp_timer_pkg::IRQ_COUNT-1:0] irq_status_q;
    logic [gp_timer_pkg::IRQ_COUNT-1:0] irq_status_d;
    logic [gp_timer_pkg::IRQ_COUNT-1:0] irq_mask_q;
    logic [gp_timer_pkg::IRQ_COUNT-1:0] irq_mask_d;
    logic [gp_timer_pkg::IRQ_COUNT-1:0] irq_events;
    logic irq_q;
    logic irq_d;
    logic half_mode_q;
    logic half_mode_d;
    logic [31:0] tally_latch_q;
    logic [31:0] tally_latch_d;
    logic tally_held_q;
    logic tally_held_d;
    logic [31:0] rd_data_q;
    logic [31:0] rd_data_d;
    logic [TALLY_WIDTH-1:0] tally_count;
    logic tally_wrap;
    logic [7:0] word_addr;
    logic wr_config;
    logic wr_mask;
    logic wr_bus_config;
    logic rd_status;
    logic rd_tally;
    logic run_bit;

    // ==========================================================
    // Free-running tally.
    // ==========================================================
    // The tally lives in its own module: its only control input is ce_in, and it must never be stopped by software.
    cycle_tally_counter #(
        .COUNT_WIDTH(TALLY_WIDTH),
        .DIV(gp_timer_pkg::TALLY_DIV),
        .SETTLE_CYCLES(gp_timer_pkg::TALLY_SETTLE_CYCLES)
    ) u_cycle_tally (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .count_out(tally_count),
        .wrap_out(tally_wrap)
    );

    // ==========================================================
    // Address decode.
    // ==========================================================
    // Bit 1 of the address picks a half only in half-word mode, so whole-word decode ignores it.
    always_comb
    begin
        word_addr = {reg_req_in.addr[7:2], 2'b00};
        wr_config = reg_req_in.wr && (word_addr == gp_timer_pkg::OFFSET_TIMER_CONFIG);
        wr_mask = reg_req_in.wr && (word_addr == gp_timer_pkg::OFFSET_IRQ_MASK);
        wr_bus_config = reg_req_in.wr && (word_addr == gp_timer_pkg::OFFSET_BUS_CONFIG);
        rd_status = reg_req_in.rd && (word_addr == gp_timer_pkg::OFFSET_IRQ_STATUS);
        rd_tally = reg_req_in.rd && (word_addr == gp_timer_pkg::OFFSET_CYCLE_TALLY);
        run_bit = reg_req_in.wdata[gp_timer_pkg::TIMER_ENABLE_BIT];
    end

    // ==========================================================
    // General purpose timer.
    // ==========================================================
    // The run state is the enable bit itself; the preload and count follow it.
    always_comb
    begin
        state_d = state_q;
        preload_d = preload_q;
        count_d = count_q;
        prescale_d = prescale_q;
        timer_event = 1'b0;
        case (state_q)
            gp_timer_pkg::TIMER_HALTED:
            begin
                // A halted timer keeps its count so software can still read where it stopped.
                prescale_d = 16'h0000;
                if (wr_config)
                begin
                    preload_d = reg_req_in.wdata[gp_timer_pkg::PRELOAD_WIDTH-1:0];
                    if (run_bit)
                    begin
                        state_d = gp_timer_pkg::TIMER_RUNNING;
                        count_d = reg_req_in.wdata[gp_timer_pkg::PRELOAD_WIDTH-1:0];
                    end
                end
            end
            gp_timer_pkg::TIMER_RUNNING:
            begin
                if (prescale_q == 16'(TICK_DIV - 1))
                begin
                    prescale_d = 16'h0000;
                    if (count_q == 16'h0000)
                    begin
                        timer_event = 1'b1;
                        count_d = preload_q;
                    end
                    else
                    begin
                        count_d = count_q - 16'h0001;
                    end
                end
                else
                begin
                    prescale_d = prescale_q + 16'h0001;
                end
                if (wr_config)
                begin
                    // A new preload takes effect at the next reload, not on the count in flight.
                    preload_d = reg_req_in.wdata[gp_timer_pkg::PRELOAD_WIDTH-1:0];
                    if (!run_bit)
                    begin
                        state_d = gp_timer_pkg::TIMER_HALTED;
                        preload_d = gp_timer_pkg::PRELOAD_PRESET;
                    end
                end
            end
            default:
            begin
                state_d = gp_timer_pkg::TIMER_HALTED;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_q <= gp_timer_pkg::TIMER_HALTED;
            preload_q <= gp_timer_pkg::PRELOAD_RESET;
            count_q <= gp_timer_pkg::COUNT_RESET;
            prescale_q <= 16'h0000;
        end
        else if (ce_in)
        begin
            state_q <= state_d;
            preload_q <= preload_d;
            count_q <= count_d;
            prescale_q <= prescale_d;
        end
    end

    // ==========================================================
    // Interrupt status, mask and output.
    // ==========================================================
    assign irq_events[gp_timer_pkg::IRQ_TIMER_BIT] = timer_event;
    assign irq_events[gp_timer_pkg::IRQ_TALLY_WRAP_BIT] = tally_wrap;

    // Each status bit is sticky; a read clears it, but an event in the same cycle wins.
    genvar bit_idx;
    generate
        for (bit_idx = 0; bit_idx < gp_timer_pkg::IRQ_COUNT; bit_idx = bit_idx + 1)
        begin : g_irq_bit
            always_comb
            begin
                if (irq_events[bit_idx])
                begin
                    irq_status_d[bit_idx] = 1'b1;
                end
                else if (rd_status)
                begin
                    irq_status_d[bit_idx] = 1'b0;
                end
                else
                begin
                    irq_status_d[bit_idx] = irq_status_q[bit_idx];
                end
            end
        end
    endgenerate

    // The output is registered from the next status and mask, so it changes in the same cycle as the status.
    always_comb
    begin
        irq_mask_d = irq_mask_q;
        if (wr_mask)
        begin
            irq_mask_d = reg_req_in.wdata[gp_timer_pkg::IRQ_COUNT-1:0];
        end
        irq_d = |(irq_status_d & irq_mask_d);
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            irq_status_q <= '0;
            irq_mask_q <= gp_timer_pkg::IRQ_MASK_RESET;
            irq_q <= 1'b0;
        end
        else if (ce_in)
        begin
            irq_status_q <= irq_status_d;
            irq_mask_q <= irq_mask_d;
            irq_q <= irq_d;
        end
    end

    // ==========================================================
    // Half-word mode and tally snapshot.
    // ==========================================================
    // The snapshot pairs any two tally reads in half-word mode; a lone first read leaves it held until the next tally read or a bus config write.
    always_comb
    begin
        half_mode_d = half_mode_q;
        tally_latch_d = tally_latch_q;
        tally_held_d = tally_held_q;
        if (wr_bus_config)
        begin
            half_mode_d = reg_req_in.wdata[gp_timer_pkg::HALF_MODE_BIT];
            tally_held_d = 1'b0;
        end
        else if (rd_tally && half_mode_q)
        begin
            if (tally_held_q)
            begin
                tally_held_d = 1'b0;
            end
            else
            begin
                tally_latch_d = 32'(tally_count);
                tally_held_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            half_mode_q <= 1'b0;
            tally_latch_q <= 32'h0000_0000;
            tally_held_q <= 1'b0;
        end
        else if (ce_in)
        begin
            half_mode_q <= half_mode_d;
            tally_latch_q <= tally_latch_d;
            tally_held_q <= tally_held_d;
        end
    end

    // ==========================================================
    // Read data.
    // ==========================================================
    // Data stand for one cycle only; idle cycles and unmapped addresses read as zero.
    always_comb
    begin
        logic [31:0] word;
        logic [31:0] tally_view;
        word = 32'h0000_0000;
        tally_view = tally_held_q ? tally_latch_q : 32'(tally_count);
        case (word_addr)
            gp_timer_pkg::OFFSET_TIMER_CONFIG:
            begin
                word[gp_timer_pkg::TIMER_ENABLE_BIT] = (state_q == gp_timer_pkg::TIMER_RUNNING);
                word[15:0] = preload_q;
            end
            gp_timer_pkg::OFFSET_TIMER_COUNT:
            begin
                word[15:0] = count_q;
            end
            gp_timer_pkg::OFFSET_CYCLE_TALLY:
            begin
                word = tally_view;
            end
            gp_timer_pkg::OFFSET_IRQ_STATUS:
            begin
                word[gp_timer_pkg::IRQ_COUNT-1:0] = irq_status_q;
            end
            gp_timer_pkg::OFFSET_IRQ_MASK:
            begin
                word[gp_timer_pkg::IRQ_COUNT-1:0] = irq_mask_q;
            end
            gp_timer_pkg::OFFSET_BUS_CONFIG:
            begin
                word[gp_timer_pkg::HALF_MODE_BIT] = half_mode_q;
            end
            default:
            begin
                word = 32'h0000_0000;
            end
        endcase
        if (!reg_req_in.rd)
        begin
            rd_data_d = 32'h0000_0000;
        end
        else if (half_mode_q)
        begin
            // In half-word mode the selected half sits in the low sixteen bits.
            rd_data_d = {16'h0000, reg_req_in.addr[gp_timer_pkg::HALF_SELECT_BIT] ? word[31:16] : word[15:0]};
        end
        else
        begin
            rd_data_d = word;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rd_data_q <= 32'h0000_0000;
        end
        else if (ce_in)
        begin
            rd_data_q <= rd_data_d;
        end
    end

    assign rd_data_out = rd_data_q;
    assign irq_out = irq_q;

endmodule : gp_timer_and_cycle_counter

/* File: hw/gp_timer_pkg.sv */
package gp_timer_pkg;

    // ==========================================================
    // Register map, byte addresses on the 32-bit register port.
    // ==========================================================
    localparam int ADDR_WIDTH = 8;
    localparam int DATA_WIDTH = 32;
    localparam logic [7:0] OFFSET_TIMER_CONFIG = 8'h8C;
    localparam logic [7:0] OFFSET_TIMER_COUNT = 8'h90;
    localparam logic [7:0] OFFSET_CYCLE_TALLY = 8'h9C;
    localparam logic [7:0] OFFSET_IRQ_STATUS = 8'hC0;
    localparam logic [7:0] OFFSET_IRQ_MASK = 8'hC4;
    localparam logic [7:0] OFFSET_BUS_CONFIG = 8'hC8;

    // ==========================================================
    // Field positions and reset values.
    // ==========================================================
    localparam int TIMER_ENABLE_BIT = 29;
    localparam int PRELOAD_WIDTH = 16;
    localparam logic [15:0] PRELOAD_RESET = 16'hFFFF;
    localparam logic [15:0] COUNT_RESET = 16'hFFFF;
    localparam logic [15:0] PRELOAD_PRESET = 16'hFFFF;
    localparam int HALF_MODE_BIT = 0;
    localparam int HALF_SELECT_BIT = 1;
    localparam int IRQ_COUNT = 2;
    localparam int IRQ_TIMER_BIT = 0;
    localparam int IRQ_TALLY_WRAP_BIT = 1;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

    // ==========================================================
    // Timing.
    // ==========================================================
    localparam int CLK_PERIOD_NS = 20;
    localparam int CLK_FREQ_HZ = 50000000;
    localparam int TALLY_FREQ_HZ = 25000000;
    localparam int TALLY_DIV = CLK_FREQ_HZ / TALLY_FREQ_HZ;
    localparam int TALLY_SETTLE_NS = 160;
    // A longest time: rounded down, but never below one cycle.
    localparam int TALLY_SETTLE_CYCLES = (TALLY_SETTLE_NS / CLK_PERIOD_NS < 1) ? 1
        : TALLY_SETTLE_NS / CLK_PERIOD_NS;
    localparam int TIMER_TICK_DIV_DEFAULT = 2;

    // ==========================================================
    // Types.
    // ==========================================================
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

    typedef enum logic [0:0] {
        TIMER_HALTED = 1'b0,
        TIMER_RUNNING = 1'b1
    } timer_state_type;

endpackage : gp_timer_pkg

/* File: testbench/gp_timer_monitor.sv */
`timescale 1ns/100ps

// ==========================================================
// Port checks for the timer and tally registers.
// ==========================================================
module gp_timer_monitor #(
    parameter int TICK_DIV = 2,
    parameter int TALLY_WIDTH = 32
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire gp_timer_pkg::reg_req_type reg_req_in,
    input wire logic [31:0] rd_data_out,
    input wire logic irq_out
);
    localparam logic [31:0] TMASK = (TALLY_WIDTH >= 32) ? 32'hFFFF_FFFF : (32'h1 << TALLY_WIDTH) - 32'h1;
    logic [5:0] word;
    logic rd, wr;
    logic [3:0] age_q, age_d;
    logic [1:0] mask_q, mask_d;
    logic run_q, run_d, half_q, half_d, preset_q, preset_d;

    // Word decode as the block sees it; writes only land while enabled.
    assign word = reg_req_in.addr[7:2];
    assign rd = reg_req_in.rd;
    assign wr = reg_req_in.wr & ce_in;

    // Shadows of mask, run and width mode, so checks need no peek inside.
    always_comb
    begin
        age_d = (age_q == 4'hF) ? age_q : age_q + 4'h1; // Saturates to stay cheap.
        mask_d = (wr && word == 6'h31) ? reg_req_in.wdata[1:0] : mask_q;
        half_d = (wr && word == 6'h32) ? reg_req_in.wdata[0] : half_q;
        run_d = (wr && word == 6'h23) ? reg_req_in.wdata[29] : run_q;
        preset_d = (wr && word == 6'h23) ? (run_q & ~reg_req_in.wdata[29]) : preset_q;
    end

    // Register the shadows.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            age_q <= 4'h0;
            mask_q <= 2'h0;
            half_q <= 1'b0;
            run_q <= 1'b0;
            preset_q <= 1'b1;
        end
        else
        begin
            age_q <= age_d;
            mask_q <= mask_d;
            half_q <= half_d;
            run_q <= run_d;
            preset_q <= preset_d;
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // ==========================================================
    // Properties.
    // ==========================================================
    sequence s_tally_rd;
        rd && word == 6'h27 && !half_q;
    endsequence
    property p_idle_zero;
        !$past(rd) |-> rd_data_out == 32'h0;
    endproperty
    property p_count_upper;
        $past(rd && word == 6'h24) |-> rd_data_out[31:16] == 16'h0;
    endproperty
    property p_config_resv;
        $past(rd && word == 6'h23 && !half_q) |-> rd_data_out[31:30] == 2'h0 && rd_data_out[28:16] == 13'h0;
    endproperty
    property p_run_readback;
        $past(rd && word == 6'h23 && !half_q) |-> rd_data_out[29] == $past(run_q);
    endproperty
    property p_preload_ffff;
        $past(rd && word == 6'h23 && !half_q && preset_q) |-> rd_data_out[15:0] == 16'hFFFF;
    endproperty
    property p_irq_masked;
        irq_out |-> (mask_q | $past(mask_q)) != 2'h0;
    endproperty
    property p_tally_settle;
        rd && word == 6'h27 && age_q < 4'h4 |=> rd_data_out == 32'h0;
    endproperty
    property p_tally_step;
        s_tally_rd ##1 s_tally_rd |=> ((rd_data_out - $past(rd_data_out)) & TMASK) <= 32'h1;
    endproperty

    a_idle_zero: assert property (p_idle_zero) else $error("read data not idle");
    a_count_upper: assert property (p_count_upper) else $error("count upper half set");
    a_config_resv: assert property (p_config_resv) else $error("config reserved bits set");
    a_run_readback: assert property (p_run_readback) else $error("run bit readback wrong");
    a_preload_ffff: assert property (p_preload_ffff) else $error("preload not preset");
    a_irq_masked: assert property (p_irq_masked) else $error("interrupt while masked");
    a_tally_settle: assert property (p_tally_settle) else $error("tally not zero after reset");
    a_tally_step: assert property (p_tally_step) else $error("tally step wrong");

    c_irq: cover property (irq_out);
    c_half_tally: cover property (rd && word == 6'h27 && half_q);
    c_halt: cover property (wr && word == 6'h23 && run_q && !reg_req_in.wdata[29]);
endmodule : gp_timer_monitor

bind gp_timer_and_cycle_counter gp_timer_monitor #(.TICK_DIV(TICK_DIV), .TALLY_WIDTH(TALLY_WIDTH)) u_monitor (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .reg_req_in(reg_req_in),
    .rd_data_out(rd_data_out),
    .irq_out(irq_out)
);

/* File: testbench/tb_top.sv */
`timescale 1ns/100ps

// ==========================================================
// Self-checking bench for the timer and tally registers.
// ==========================================================
module tb_top;
    localparam int TICK = 1;
    localparam int TW = 12;
    localparam logic [31:0] TMASK = 32'h0000_0FFF;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic ce_in = 1'b1;
    gp_timer_pkg::reg_req_type req = '0;
    logic [31:0] rd_data_out;
    logic irq_out;
    logic irq_prev = 1'b0;
    logic [31:0] a, b, x;
    logic [7:0] ra [6] = '{8'h9C, 8'h8C, 8'h90, 8'hC4, 8'hC0, 8'h40};
    logic [31:0] rx [6] = '{32'h0, 32'h0000_FFFF, 32'h0000_FFFF, 32'h0, 32'h0, 32'h0};
    int miscompares = 0;
    int cmp_count = 0;
    int cycle_count = 0;
    int rise_q [$];
    int unsigned pre, m, g;

    // A short tally keeps the wrap within reach of the run.
    gp_timer_and_cycle_counter #(.TICK_DIV(TICK), .TALLY_WIDTH(TW)) u_dut (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .reg_req_in(req),
        .rd_data_out(rd_data_out),
        .irq_out(irq_out)
    );

    // The 50 MHz clock.
    initial
    begin
        forever #10 clk_in = ~clk_in;
    end

    // Cycle count, interrupt rise times and the hang limit.
    always @(posedge clk_in)
    begin
        cycle_count++;
        if (irq_out === 1'b1 && irq_prev !== 1'b1)
            rise_q.push_back(cycle_count);
        irq_prev = irq_out;
        if (cycle_count == 20000)
        begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One or two back-to-back transfers; read answers are caught at the falling edge.
    task automatic acc(input logic w, input logic [7:0] ad, input logic [31:0] d, input int n);
        @(posedge clk_in);
        req <= '{ad, d, w, ~w};
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_in);
            if (i == n - 1)
                req <= '0;
            @(negedge clk_in);
            if (i == 0)
                a = rd_data_out;
            else
                b = rd_data_out;
        end
    endtask : acc

    task automatic rd_chk(input logic [7:0] ad, input logic [31:0] exp);
        acc(1'b0, ad, 32'h0, 1);
        check(a, exp);
    endtask : rd_chk

    task automatic wait_rise(input int k);
        g = 0;
        while (rise_q.size() < k && g < 10000)
        begin
            @(negedge clk_in);
            g++;
        end
    endtask : wait_rise

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish

    // Main sequence.
    initial
    begin
        void'($urandom(32'hCFFB0730));
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        for (int i = 0; i < 6; i++)
            rd_chk(ra[i], rx[i]);
        acc(1'b1, 8'h90, 32'h1234_5678, 1);
        acc(1'b1, 8'h40, 32'hFFFF_FFFF, 1);
        rd_chk(8'h90, 32'h0000_FFFF);
        rd_chk(8'h40, 32'h0);
        $display("test reset values done");
        pre = $urandom_range(16'hFFF0, 16'h0100);
        acc(1'b1, 8'h8C, 32'h2000_0000 | pre, 1);
        rd_chk(8'h8C, 32'h2000_0000 | pre);
        acc(1'b0, 8'h90, 32'h0, 2);
        check(a, pre - 3);
        check(b, pre - 4);
        x = $urandom;
        acc(1'b1, 8'h8C, {16'h0, x[15:0]}, 1);
        rd_chk(8'h8C, 32'h0000_FFFF);
        acc(1'b0, 8'h90, 32'h0, 2);
        check(a, pre - 7);
        check(b, pre - 7);
        $display("test run and halt done");
        // Timer events, first masked, then measured period by period.
        pre = $urandom_range(12, 6);
        acc(1'b1, 8'h8C, 32'h2000_0000 | pre, 1);
        repeat (40) @(posedge clk_in);
        @(negedge clk_in);
        check(irq_out, 32'h0);
        rd_chk(8'hC0, 32'h1);
        acc(1'b1, 8'hC4, 32'h1, 1);
        rise_q.delete();
        for (int i = 1; i <= 4; i++)
        begin
            wait_rise(i);
            acc(1'b0, 8'hC0, 32'h0, 1);
        end
        check(rise_q[2] - rise_q[1], (pre + 1) * TICK);
        check(rise_q[3] - rise_q[2], (pre + 1) * TICK);
        acc(1'b1, 8'h8C, 32'h0, 1);
        acc(1'b0, 8'hC0, 32'h0, 1);
        rd_chk(8'hC0, 32'h0);
        @(negedge clk_in);
        check(irq_out, 32'h0);
        $display("test interrupts done");
        // Tally reads an even number of cycles apart differ by half the gap.
        for (int i = 0; i < 4; i++)
        begin
            m = 2 * $urandom_range(20, 0);
            acc(1'b0, 8'h9C, 32'h0, 1);
            x = a;
            repeat (m) @(posedge clk_in);
            acc(1'b0, 8'h9C, 32'h0, 2);
            check((a - x) & TMASK, 1 + m / 2);
        end
        $display("test tally rate done");
        // A low clock enable freezes the tally: only four enabled edges pass between the two reads.
        acc(1'b0, 8'h9C, 32'h0, 1);
        x = a;
        repeat (2) @(posedge clk_in);
        ce_in <= 1'b0;
        m = $urandom_range(30, 5);
        repeat (m) @(posedge clk_in);
        ce_in <= 1'b1;
        acc(1'b0, 8'h9C, 32'h0, 1);
        check((a - x) & TMASK, 32'h2);
        $display("test clock enable done");
        acc(1'b1, 8'hC8, 32'h1, 1);
        acc(1'b0, 8'h9E, 32'h0, 1);
        check(a, 32'h0);
        m = 2 * $urandom_range(20, 1);
        repeat (m) @(posedge clk_in);
        acc(1'b0, 8'h9C, 32'h0, 1);
        x = a;
        acc(1'b0, 8'h9C, 32'h0, 1);
        check((a - x) & TMASK, 2 + m / 2);
        acc(1'b1, 8'hC8, 32'h0, 1);
        $display("test half word latch done");
        acc(1'b1, 8'hC4, 32'h2, 1);
        rise_q.delete();
        wait_rise(1);
        rd_chk(8'hC0, 32'h2);
        acc(1'b0, 8'h9C, 32'h0, 1);
        check(a >> 4, 32'h0);
        $display("test tally wrap done");
        tally_and_finish();
    end
endmodule : tb_top
